// ==== dv/slsw_ctrl_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module slsw_ctrl_asserts (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_n,
  // serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  // static configuration pins
  input wire logic pulldown_disable,
  input wire logic short_latchoff_disable,
  // load stage controls
  input wire logic [7:0] sink_en,
  input wire logic [7:0] pulldown_en,
  input wire logic [7:0] openload_det_en,
  input wire logic [7:0] short_latch_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_rst_clear: assert property ($fell(rst) |-> !sink_en && !pulldown_en)
    else $error("outputs set after rst");
  chk_rstn_off: assert property (!reset_n [*6] |-> !sink_en && !short_latch_en)
    else $error("outputs set in reset");
  chk_rstn_pull: assert property (!reset_n [*6] |-> !pulldown_en)
    else $error("pulldown on in reset");
  chk_pull_on: assert property ((reset_n && $stable(pulldown_disable)) [*6]
    |-> pulldown_en == {8{!pulldown_disable}}) else $error("pulldown_en wrong");
  chk_open_det: assert property ((reset_n && $stable(pulldown_disable)) [*6]
    |-> openload_det_en == {8{!pulldown_disable}}) else $error("openload wrong");
  chk_latch_off: assert property ((reset_n && $stable(short_latchoff_disable))
    [*6] |-> short_latch_en == {8{!short_latchoff_disable}}) else $error("latch wrong");
  chk_sink_hold: assert property ((!cs_n && reset_n) [*8] |=> $stable(sink_en))
    else $error("sink_en moved in frame");
  chk_dout_hold: assert property ((!cs_n && sclk && reset_n) [*4] |=> $stable(dout))
    else $error("dout moved while clock high");
endmodule
bind slsw_ctrl slsw_ctrl_asserts chk_u (.core_clk, .rst, .reset_n, .cs_n, .sclk, .dout,
  .pulldown_disable, .short_latchoff_disable, .sink_en, .pulldown_en, .openload_det_en,
  .short_latch_en);
`default_nettype wire

// ==== dv/slsw_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module slsw_host (
  // serial bus
  input wire logic core_clk,
  input wire logic dout,
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic din = 1'b0
);
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // msb first; dout sampled just before each rising clock edge
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din <= tx[i];
      tick(4);
      rx[i] = dout;
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
    tick(4);
    din <= ~din;
    cs_n <= 1'b1;
    tick(8);
  endtask
  task automatic noise();
    repeat (8) begin
      sclk <= ~sclk;
      din <= ~din;
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/test_slsw_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_slsw_ctrl;
  logic core_clk = 1'b0, rst = 1'b1, reset_n = 1'b1, cs_n, sclk, din, dout;
  logic pulldown_disable = 1'b0, short_latchoff_disable = 1'b0;
  logic [7:0] fault_in = 8'h00, ctrl = 8'h00;
  logic [7:0] sink_en, pulldown_en, openload_det_en, short_latch_en;
  logic [15:0] rx;
  logic [15:0] txs [4] = '{16'h00a5, 16'h3c5a, 16'hff01, 16'h0080};
  logic [7:0] fins [4] = '{8'h00, 8'h81, 8'h00, 8'h00};
  logic [7:0] flts [4] = '{8'h00, 8'h81, 8'h81, 8'h00};
  int err_total = 0, comparisons = 0;
  initial forever #10 core_clk = ~core_clk;
  slsw_host host_u (.core_clk, .dout, .cs_n, .sclk, .din);
  slsw_ctrl dut_u (.core_clk, .rst, .reset_n, .cs_n, .sclk, .din, .dout, .pulldown_disable,
    .short_latchoff_disable, .fault_in, .sink_en, .pulldown_en, .openload_det_en,
    .short_latch_en);
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst <= 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      fault_in <= fins[i];
      repeat (4) @(negedge core_clk);
      host_u.frame(txs[i], rx);
      cmp("dout", {ctrl ^ flts[i], txs[i][15:8]}, rx);
      cmp("dout_idle", 16'(txs[i][7]), 16'(dout));
      ctrl = txs[i][7:0];
      cmp("sink_en", 16'(ctrl), 16'(sink_en));
    end
    host_u.noise();
    repeat (8) @(negedge core_clk);
    cmp("sink_en", 16'h0080, 16'(sink_en));
    cmp("dout_idle", 16'h0001, 16'(dout));
    cmp("pulldown_en", 16'h00ff, 16'(pulldown_en));
    cmp("openload_det_en", 16'h00ff, 16'(openload_det_en));
    reset_n <= 1'b0;
    repeat (8) @(negedge core_clk);
    cmp("sink_en", 16'h0000, 16'(sink_en));
    cmp("pulldown_en", 16'h0000, 16'(pulldown_en));
    reset_n <= 1'b1;
    pulldown_disable <= 1'b1;
    repeat (8) @(negedge core_clk);
    cmp("openload_det_en", 16'h0000, 16'(openload_det_en));
    cmp("pulldown_en", 16'h0000, 16'(pulldown_en));
    cmp("short_latch_en", 16'h00ff, 16'(short_latch_en));
    short_latchoff_disable <= 1'b1;
    repeat (8) @(negedge core_clk);
    cmp("short_latch_en", 16'h0000, 16'(short_latch_en));
    summarize();
  end
endmodule
`default_nettype wire

// ==== hw/slsw_ctrl.sv ====
// Summary of operation
// [RULE_01] reset clears every register; all eight load outputs turn off
// [RULE_02] reset also disables all pulldown current sources regardless of input
// [RULE_03] host lowers chip select before data and holds it low throughout
// [RULE_04] serial input sampled on serial clock rising edges into 8-bit shifter
// [RULE_05] chip select rising edge copies shifter into output control register
// [RULE_06] serial output shows shifter msb, changing on serial clock falling edges
// [RULE_07] serial output can feed the serial input of a chained device
// [RULE_08] pulldown_disable high turns pulldown sources off, low turns them on
// [RULE_09] open-load detection allowed only while pulldown_disable is low
// [RULE_10] short_latchoff_disable low latches overloaded channel off, high never
// [RULE_11] each output sinks to power ground when its control bit is set
// [RULE_12] command bit 7 drives channel 8, bit 0 drives channel 1
// [RULE_13] chip select falling edge loads per-channel status into the shifter
// [RULE_14] only the last 8 bits clocked in are kept and latched
// [RULE_15] status equals command bit without fault, inverse with latched fault
// [RULE_16] while chip select is high serial activity is ignored
`timescale 1ns/1ns
`default_nettype none
module slsw_ctrl
  import slsw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_n,
  // serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  // static configuration pins
  input wire logic pulldown_disable,
  input wire logic short_latchoff_disable,
  // analog stage fault detectors, one per channel
  input wire logic [7:0] fault_in,
  // load stage controls
  output logic [7:0] sink_en,
  output logic [7:0] pulldown_en,
  output logic [7:0] openload_det_en,
  output logic [7:0] short_latch_en
);

  // ---------------------------------------------------------------
  // serial pin synchronisers
  // ---------------------------------------------------------------
  slsw_pins_t meta_q;
  slsw_pins_t pins_q;
  slsw_pins_t prev_q;
  slsw_edges_t edg;

  // every stage resets to the idle levels so no false edge follows reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= PINS_IDLE;
      pins_q <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end else begin
      meta_q <= '{cs_n: cs_n, sclk: sclk, din: din};
      pins_q <= meta_q;
      prev_q <= pins_q;
    end
  end

  // ---------------------------------------------------------------
  // device reset pin synchroniser
  // ---------------------------------------------------------------
  logic rst_n_meta_q;
  logic rst_n_sync_q;
  logic dev_clr;

  // starts cleared, so nothing is latched before the pin is seen high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_n_meta_q <= 1'b0;
      rst_n_sync_q <= 1'b0;
    end else begin
      rst_n_meta_q <= reset_n;
      rst_n_sync_q <= rst_n_meta_q;
    end
  end
  assign dev_clr = !rst_n_sync_q;

  // ---------------------------------------------------------------
  // static configuration pin synchronisers
  // ---------------------------------------------------------------
  logic pulldown_disable_s1_q;
  logic pulldown_disable_s2_q;
  logic latchoff_disable_s1_q;
  logic latchoff_disable_s2_q;

  // static levels are still pins, so they pass two flops like the rest
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulldown_disable_s1_q <= 1'b0;
      pulldown_disable_s2_q <= 1'b0;
      latchoff_disable_s1_q <= 1'b0;
      latchoff_disable_s2_q <= 1'b0;
    end else begin
      pulldown_disable_s1_q <= pulldown_disable;
      pulldown_disable_s2_q <= pulldown_disable_s1_q;
      latchoff_disable_s1_q <= short_latchoff_disable;
      latchoff_disable_s2_q <= latchoff_disable_s1_q;
    end
  end

  // clock edges count only once chip select was already low a cycle
  always_comb begin
    edg.cs_fall = prev_q.cs_n && !pins_q.cs_n;
    edg.cs_rise = !prev_q.cs_n && pins_q.cs_n;
    edg.sclk_rise = !pins_q.cs_n && !prev_q.cs_n && !prev_q.sclk && pins_q.sclk; // see [RULE_16]
    edg.sclk_fall = !pins_q.cs_n && !prev_q.cs_n && prev_q.sclk && !pins_q.sclk; // see [RULE_16]
  end

  // ---------------------------------------------------------------
  // fault status latch
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] fault_q;
  logic [7:0] fault_s1_q;
  logic [7:0] fault_s2_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_s1_q <= 8'h00;
      fault_s2_q <= 8'h00;
    end else begin
      fault_s1_q <= fault_in;
      fault_s2_q <= fault_s1_q;
    end
  end

  // a fault arriving with the clearing edge is kept
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 8'h00;
    end else if (dev_clr) begin
      fault_q <= 8'h00; // see [RULE_01]
    end else if (edg.cs_rise) begin
      fault_q <= fault_s2_q;
    end else begin
      fault_q <= fault_q | fault_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // shift register and output control register
  // ---------------------------------------------------------------
  logic [7:0] shift_q;
  logic [7:0] status;
  logic dout_q;

  assign status = ctrl_q ^ fault_q; // see [RULE_15]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_q <= SHIFT_RESET;
    end else if (dev_clr) begin
      shift_q <= SHIFT_RESET; // see [RULE_01]
    end else if (edg.cs_fall) begin
      shift_q <= status; // see [RULE_13]
    end else if (edg.sclk_rise) begin
      shift_q <= {shift_q[6:0], pins_q.din}; // see [RULE_04] see [RULE_14]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (dev_clr) begin
      ctrl_q <= CTRL_RESET; // see [RULE_01]
    end else if (edg.cs_rise) begin
      ctrl_q <= shift_q; // see [RULE_05]
    end
  end

  // msb leaves first: status msb shows from the select fall, the rest on falling edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dout_q <= 1'b0;
    end else if (dev_clr) begin
      dout_q <= 1'b0;
    end else if (edg.cs_fall) begin
      dout_q <= status[7]; // see [RULE_13]
    end else if (pins_q.cs_n || edg.sclk_fall) begin
      dout_q <= shift_q[7]; // see [RULE_06] see [RULE_07]
    end
  end
  assign dout = dout_q;

  // ---------------------------------------------------------------
  // per-channel output stage controls
  // ---------------------------------------------------------------
  slsw_drive_t drv_q;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        drv_q.sink_en[ch] <= 1'b0;
        drv_q.pulldown_en[ch] <= 1'b0;
        drv_q.openload_det_en[ch] <= 1'b0;
        drv_q.short_latch_en[ch] <= 1'b0;
      end else if (dev_clr) begin
        drv_q.sink_en[ch] <= 1'b0; // see [RULE_01]
        drv_q.pulldown_en[ch] <= 1'b0; // see [RULE_02]
        drv_q.openload_det_en[ch] <= 1'b0;
        drv_q.short_latch_en[ch] <= 1'b0;
      end else begin
        drv_q.sink_en[ch] <= ctrl_q[ch]; // see [RULE_11] see [RULE_12]
        drv_q.pulldown_en[ch] <= !pulldown_disable_s2_q; // see [RULE_08]
        drv_q.openload_det_en[ch] <= !pulldown_disable_s2_q; // see [RULE_09]
        drv_q.short_latch_en[ch] <= !latchoff_disable_s2_q; // see [RULE_10]
      end
    end
  end

  assign sink_en = drv_q.sink_en;
  assign pulldown_en = drv_q.pulldown_en;
  assign openload_det_en = drv_q.openload_det_en;
  assign short_latch_en = drv_q.short_latch_en;

endmodule
`default_nettype wire

// ==== hw/slsw_pkg.sv ====
package slsw_pkg;
  // channel count and control/shift register reset values
  localparam int unsigned NUM_CH = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // synchronised serial pins and their edges
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } slsw_pins_t;

  // idle pin levels, loaded into the synchronisers by reset
  localparam slsw_pins_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

  typedef struct packed {
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
  } slsw_edges_t;

  // per-channel drive, pulldown and fault enables
  typedef struct packed {
    logic [7:0] sink_en;
    logic [7:0] pulldown_en;
    logic [7:0] openload_det_en;
    logic [7:0] short_latch_en;
  } slsw_drive_t;
endpackage
